// ---- src/avc_consts.svh ----
// constants for the address and vector control instruction block
// What this block does
// - subtract writes 32-bit difference, result at phase 9
// - multiply keeps low 32 bits of product
// - back-to-back multiply holds second two phases
// - multiply path 26, result 27, unit four
// - increment k: 0 zero, 1 plus, 2 minus
// - k 3,4,7 zero; 5 plus; 6 minus
// - increment adder two phases, result phase 9
// - scalar transfer keeps low 32 bits
// - length read copies seven bits, rest zero
// - positive short constant zero filled
// - negative short constant ones filled
// - short loads: path 6, result 7
// - codes 030-033 test zero, nonzero, positive, negative
// - mask cleared; first element at top bit
// - zero length leaves mask clear, free 12
// - lengths 1-4 free 17/20, plus one each
// - scalar to mask copies 64 bits, free 11
// - clock load only while status bit 21
// - clock load forces two low bits zero
// - clock busy to 11; 115 next waits 6
// - length load clamps to 64, next phase 20
// - range codes toggle halt and float tests
// - range codes clear and set status bits
// - range errors always recorded in status
`ifndef AVC_CONSTS_SVH
`define AVC_CONSTS_SVH
// apb byte offsets
`define AVC_OFF_INSTR 8'h00
`define AVC_OFF_STATUS 8'h04
`define AVC_OFF_VLEN 8'h08
`define AVC_OFF_VM_LO 8'h0c
`define AVC_OFF_VM_HI 8'h10
`define AVC_OFF_RTC_LO 8'h14
`define AVC_OFF_RTC_HI 8'h18
`define AVC_OFF_VIDX 8'h1c
`define AVC_OFF_VDAT_LO 8'h20
`define AVC_OFF_VDAT_HI 8'h24
`define AVC_OFF_BUSY 8'h28
`define AVC_OFF_AREG 8'h40
`define AVC_OFF_SREG 8'h80
// opcodes (upper seven parcel bits)
`define AVC_OP_SUB 7'h11
`define AVC_OP_MUL 7'h12
`define AVC_OP_INC 7'h13
`define AVC_OP_S2A 7'h14
`define AVC_OP_VLRD 7'h15
`define AVC_OP_KPOS 7'h16
`define AVC_OP_KNEG 7'h17
`define AVC_OP_VMZ 7'h18
`define AVC_OP_VMN 7'h19
`define AVC_OP_VMP 7'h1a
`define AVC_OP_VMM 7'h1b
`define AVC_OP_S2VM 7'h1c
`define AVC_OP_S2RTC 7'h1d
`define AVC_OP_VLLD 7'h1e
`define AVC_OP_RNG 7'h1f
`define AVC_OP_AFT_VM 7'h4c
`define AVC_OP_AFT_RTC 7'h4d
// phases, one phase per pclk
`define AVC_PH_NEXT 8'h02
`define AVC_PH_OPND 8'h03
`define AVC_PH_PATH 8'h08
`define AVC_PH_PATH_K 8'h06
`define AVC_PH_PATH_MUL 8'h1a
`define AVC_PH_RES 8'h09
`define AVC_PH_RES_K 8'h07
`define AVC_PH_RES_MUL 8'h1b
`define AVC_PH_MUL_UNIT 8'h04
`define AVC_PH_MUL_GAP 8'h02
`define AVC_PH_VLU_ISS 8'h0a
`define AVC_PH_VLU_ISS_S 8'h08
`define AVC_PH_VM_ZERO 8'h0c
`define AVC_PH_VSRC 8'h11
`define AVC_PH_VLU_DONE 8'h14
`define AVC_PH_SHORT_ELEMS 8'h04
`define AVC_PH_S_BUSY 8'h0b
`define AVC_PH_AFTER 8'h06
`define AVC_PH_SLOW 8'h14
// status bit positions
`define AVC_ST_RD_ERR 5'h0d
`define AVC_ST_WR_ERR 5'h0e
`define AVC_ST_MEM_HALT 5'h0f
`define AVC_ST_FLT_ERR 5'h10
`define AVC_ST_FLT_TEST 5'h12
`define AVC_ST_MONITOR 5'h15
`define AVC_ST_PEND 5'h00
// misc
`define AVC_VL_MAX 32'h0000_0040
`define AVC_VL_RST 7'h40
`endif

// ---- src/avc_core.sv ----
// address and vector control instruction decoder with apb register access
//
// Design decisions made here: the address map and the APB register port.
`include "avc_consts.svh"
`default_nettype none
module avc_core
  import avc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire avc_err_type range_err,
  output logic mem_range_halt
);
  // architected state
  logic [31:0] a_q [8]; // address registers
  logic [31:0] a_pend_q [8]; // results waiting for their phase
  logic [7:0] a_cnt_q [8]; // phases until each a register is free
  logic [63:0] s_q [8]; // scalar registers, software loaded
  logic [63:0] vmem [64]; // one vector register of 64 elements
  logic [6:0] vl_q; // vector length register
  logic [63:0] vm_q; // vector mask register
  logic [63:0] rtc_q; // real-time clock
  logic [31:0] st_q; // status register
  logic [5:0] vidx_q; // element pointer for software loads
  logic [31:0] vlo_q; // low half waiting for the high half
  // issue queue of one parcel and resource counters
  logic pend_q;
  avc_parcel_type par_q;
  logic [7:0] next_cnt_q; // phases until next issue allowed
  logic [7:0] path_cnt_q; // address destination path
  logic [7:0] mul_cnt_q; // address multiply unit
  logic [7:0] add_cnt_q; // address add unit
  logic [7:0] vlu_cnt_q; // vector logical unit
  logic [7:0] vm_cnt_q; // mask register
  logic [7:0] vsrc_cnt_q; // source vector register
  logic [7:0] rtc_cnt_q; // real-time clock
  logic [7:0] since_q; // phases since last issue, saturating
  logic [6:0] last_op_q; // opcode of last issued parcel
  avc_state_type state_q;
  logic [6:0] elem_q; // element being streamed
  logic [1:0] test_q; // mask test kind
  // apb decode
  logic acc, wr, rd;
  logic instr_wr_wait;
  logic mapped;
  assign acc = psel && penable;
  assign instr_wr_wait = pwrite && paddr == `AVC_OFF_INSTR && pend_q;
  assign pready = !instr_wr_wait; // a new parcel waits while one is queued
  assign wr = acc && pready && pwrite;
  assign rd = acc && pready && !pwrite;
  // operand read with forwarding of a result not yet committed
  function automatic logic [31:0] aval(input logic [2:0] n);
    aval = (a_cnt_q[n] != 8'h00) ? a_pend_q[n] : a_q[n];
  endfunction : aval
  // ---- decode ----
  logic [31:0] opj, opk, res_d;
  logic [63:0] prod;
  logic [31:0] incv;
  logic is_a_op, can_issue, iss;
  logic [7:0] path_need, res_ph;
  logic [7:0] ext;
  assign opj = aval(par_q.j);
  assign opk = aval(par_q.k);
  assign prod = opj * opk;
  assign ext = ({1'b0, vl_q} > {1'b0, `AVC_PH_SHORT_ELEMS}) ?
               {1'b0, vl_q} - `AVC_PH_SHORT_ELEMS : 8'h00;
  // increment value per k, unlisted codes included
  always_comb begin
    case (par_q.k)
      3'h1, 3'h5: incv = 32'h0000_0001;
      3'h2, 3'h6: incv = 32'hffff_ffff;
      default: incv = 32'h0000_0000; // zero for 0, 3, 4 and 7
    endcase
  end
  // result, path phase and result phase for ops that write an a register
  always_comb begin
    is_a_op = 1'b1;
    res_d = 32'h0000_0000;
    path_need = `AVC_PH_PATH;
    res_ph = `AVC_PH_RES;
    case (par_q.op)
      `AVC_OP_SUB: res_d = opj - opk;
      `AVC_OP_MUL: begin
        res_d = prod[31:0];
        path_need = `AVC_PH_PATH_MUL;
        res_ph = `AVC_PH_RES_MUL;
      end
      `AVC_OP_INC: res_d = opj + incv;
      `AVC_OP_S2A: res_d = s_q[par_q.j][31:0];
      `AVC_OP_VLRD: begin
        res_d = {25'h0, vl_q};
        path_need = `AVC_PH_PATH_K;
        res_ph = `AVC_PH_RES_K;
      end
      `AVC_OP_KPOS: begin
        res_d = {26'h0, par_q.j, par_q.k};
        path_need = `AVC_PH_PATH_K;
        res_ph = `AVC_PH_RES_K;
      end
      `AVC_OP_KNEG: begin
        res_d = {26'h3ff_ffff, par_q.j, par_q.k};
        path_need = `AVC_PH_PATH_K;
        res_ph = `AVC_PH_RES_K;
      end
      default: is_a_op = 1'b0;
    endcase
  end
  // issue check: every needed resource free by its phase
  logic ops_jk, ops_j;
  assign ops_j = par_q.op == `AVC_OP_SUB || par_q.op == `AVC_OP_MUL ||
                 par_q.op == `AVC_OP_INC;
  assign ops_jk = par_q.op == `AVC_OP_SUB || par_q.op == `AVC_OP_MUL;
  always_comb begin
    can_issue = pend_q && next_cnt_q == 8'h00;
    if (is_a_op) begin
      if (a_cnt_q[par_q.i] > `AVC_PH_OPND) can_issue = 1'b0;
      if (path_cnt_q > path_need) can_issue = 1'b0;
      if (ops_j && a_cnt_q[par_q.j] > `AVC_PH_OPND) can_issue = 1'b0;
      if (ops_jk && a_cnt_q[par_q.k] > `AVC_PH_OPND) can_issue = 1'b0;
    end
    // unit count 4,3,2 holds a follower, so it leaves two phases after the normal slot
    if (par_q.op == `AVC_OP_MUL && mul_cnt_q >= `AVC_PH_MUL_GAP) begin
      can_issue = 1'b0;
    end
    if (par_q.op == `AVC_OP_INC && add_cnt_q != 8'h00) can_issue = 1'b0;
    if (par_q.op inside {`AVC_OP_VMZ, `AVC_OP_VMN, `AVC_OP_VMP, `AVC_OP_VMM}) begin
      if (vlu_cnt_q > `AVC_PH_VLU_ISS || vm_cnt_q > `AVC_PH_VLU_ISS) can_issue = 1'b0;
      if (state_q != AVC_IDLE) can_issue = 1'b0;
    end
    if (par_q.op == `AVC_OP_S2VM || par_q.op == `AVC_OP_S2RTC) begin
      if (vlu_cnt_q > `AVC_PH_VLU_ISS_S) can_issue = 1'b0;
    end
    if (par_q.op == `AVC_OP_S2VM && vm_cnt_q > `AVC_PH_VLU_ISS_S) can_issue = 1'b0;
    if (par_q.op == `AVC_OP_S2RTC && rtc_cnt_q > `AVC_PH_VLU_ISS_S) can_issue = 1'b0;
    if (par_q.op == `AVC_OP_VLLD && a_cnt_q[par_q.k] > `AVC_PH_OPND) can_issue = 1'b0;
    // a 114 or 115 right after a mask or clock load waits to phase 6
    if ((par_q.op == `AVC_OP_AFT_VM && last_op_q == `AVC_OP_S2VM) ||
        (par_q.op == `AVC_OP_AFT_RTC && last_op_q == `AVC_OP_S2RTC)) begin
      if (since_q < `AVC_PH_AFTER) can_issue = 1'b0;
    end
  end
  assign iss = can_issue;
  // ---- queue and issue bookkeeping ----
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend_q <= 1'b0;
      par_q <= '0;
      last_op_q <= 7'h00;
      since_q <= 8'h00;
    end else begin
      since_q <= (since_q == 8'hff) ? since_q : since_q + 8'h01;
      if (iss) begin
        pend_q <= 1'b0; // parcel consumed
        last_op_q <= par_q.op;
        since_q <= 8'h01;
      end
      if (wr && paddr == `AVC_OFF_INSTR) begin
        pend_q <= 1'b1;
        par_q <= pwdata[15:0];
      end
    end
  end
  // next-issue spacing
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      next_cnt_q <= 8'h00;
    end else if (iss) begin
      if (par_q.op == `AVC_OP_VLLD || par_q.op == `AVC_OP_RNG) begin
        next_cnt_q <= `AVC_PH_SLOW - 8'h01;
      end else begin
        next_cnt_q <= `AVC_PH_NEXT - 8'h01; // counted from the issue edge
      end
    end else if (next_cnt_q != 8'h00) begin
      next_cnt_q <= next_cnt_q - 8'h01;
    end
  end
  // shared unit counters
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      path_cnt_q <= 8'h00;
      mul_cnt_q <= 8'h00;
      add_cnt_q <= 8'h00;
    end else begin
      path_cnt_q <= (path_cnt_q != 8'h00) ? path_cnt_q - 8'h01 : 8'h00;
      mul_cnt_q <= (mul_cnt_q != 8'h00) ? mul_cnt_q - 8'h01 : 8'h00;
      add_cnt_q <= (add_cnt_q != 8'h00) ? add_cnt_q - 8'h01 : 8'h00;
      if (iss && is_a_op) path_cnt_q <= res_ph;
      if (iss && par_q.op == `AVC_OP_MUL) mul_cnt_q <= `AVC_PH_MUL_UNIT;
      if (iss && par_q.op == `AVC_OP_INC) add_cnt_q <= `AVC_PH_NEXT - 8'h01;
    end
  end
  // per address register: pending result, countdown, commit, software write
  for (genvar g = 0; g < 8; g++) begin : g_areg
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        a_q[g] <= 32'h0000_0000;
        a_pend_q[g] <= 32'h0000_0000;
        a_cnt_q[g] <= 8'h00;
      end else begin
        if (a_cnt_q[g] == 8'h01) a_q[g] <= a_pend_q[g]; // result lands at its phase
        if (a_cnt_q[g] != 8'h00) a_cnt_q[g] <= a_cnt_q[g] - 8'h01;
        if (wr && paddr == `AVC_OFF_AREG + 8'(4 * g)) a_q[g] <= pwdata;
        if (iss && is_a_op && par_q.i == 3'(g)) begin
          a_pend_q[g] <= res_d;
          a_cnt_q[g] <= res_ph;
        end
      end
    end
  end
  // scalar registers and vector element loads, written by software
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int n = 0; n < 8; n++) s_q[n] <= 64'h0;
      vidx_q <= 6'h00;
      vlo_q <= 32'h0000_0000;
    end else if (wr) begin
      for (int n = 0; n < 8; n++) begin
        if (paddr == `AVC_OFF_SREG + 8'(8 * n)) s_q[n][31:0] <= pwdata;
        if (paddr == `AVC_OFF_SREG + 8'(8 * n + 4)) s_q[n][63:32] <= pwdata;
      end
      if (paddr == `AVC_OFF_VIDX) vidx_q <= pwdata[5:0];
      if (paddr == `AVC_OFF_VDAT_LO) vlo_q <= pwdata;
      if (paddr == `AVC_OFF_VDAT_HI) vidx_q <= vidx_q + 6'h01; // auto step
    end
  end
  // element storage has no reset; software loads it before use
  always_ff @(posedge pclk) begin
    if (wr && paddr == `AVC_OFF_VDAT_HI) vmem[vidx_q] <= {pwdata, vlo_q};
  end
  // ---- mask from element tests ----
  logic [63:0] elem;
  logic pass;
  assign elem = vmem[elem_q[5:0]];
  always_comb begin
    case (test_q)
      2'h0: pass = elem == 64'h0;
      2'h1: pass = elem != 64'h0;
      2'h2: pass = !elem[63];
      default: pass = elem[63];
    endcase
  end
  logic mask_iss;
  assign mask_iss = iss && par_q.op inside {`AVC_OP_VMZ, `AVC_OP_VMN, `AVC_OP_VMP,
                                              `AVC_OP_VMM};
  // streaming sequencer, one element per phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= AVC_IDLE;
      elem_q <= 7'h00;
      test_q <= 2'h0;
    end else begin
      case (state_q)
        AVC_IDLE: begin
          if (mask_iss && vl_q != 7'h00) begin
            state_q <= AVC_STREAM;
            elem_q <= 7'h00;
            test_q <= par_q.op[1:0];
          end
        end
        AVC_STREAM: begin
          elem_q <= elem_q + 7'h01;
          if (elem_q + 7'h01 >= vl_q) state_q <= AVC_IDLE;
        end
        default: state_q <= AVC_IDLE;
      endcase
    end
  end
  // mask register: cleared at test issue, filled from the top bit down
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vm_q <= 64'h0;
    end else if (mask_iss) begin
      vm_q <= 64'h0;
    end else if (iss && par_q.op == `AVC_OP_S2VM) begin
      vm_q <= s_q[par_q.j];
    end else if (state_q == AVC_STREAM && pass) begin
      vm_q[6'h3f - elem_q[5:0]] <= 1'b1;
    end
  end
  // vector unit counters; long vectors stretch by one phase per element
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vlu_cnt_q <= 8'h00;
      vm_cnt_q <= 8'h00;
      vsrc_cnt_q <= 8'h00;
      rtc_cnt_q <= 8'h00;
    end else begin
      vlu_cnt_q <= (vlu_cnt_q != 8'h00) ? vlu_cnt_q - 8'h01 : 8'h00;
      vm_cnt_q <= (vm_cnt_q != 8'h00) ? vm_cnt_q - 8'h01 : 8'h00;
      vsrc_cnt_q <= (vsrc_cnt_q != 8'h00) ? vsrc_cnt_q - 8'h01 : 8'h00;
      rtc_cnt_q <= (rtc_cnt_q != 8'h00) ? rtc_cnt_q - 8'h01 : 8'h00;
      if (mask_iss && vl_q == 7'h00) begin
        vm_cnt_q <= `AVC_PH_VM_ZERO;
        vlu_cnt_q <= `AVC_PH_VM_ZERO;
      end else if (mask_iss) begin
        vm_cnt_q <= `AVC_PH_VLU_DONE + ext;
        vlu_cnt_q <= `AVC_PH_VLU_DONE + ext;
        vsrc_cnt_q <= `AVC_PH_VSRC + ext;
      end
      if (iss && par_q.op == `AVC_OP_S2VM) begin
        vm_cnt_q <= `AVC_PH_S_BUSY;
        vlu_cnt_q <= `AVC_PH_VLU_ISS_S;
      end
      if (iss && par_q.op == `AVC_OP_S2RTC) begin
        rtc_cnt_q <= `AVC_PH_S_BUSY;
        vlu_cnt_q <= `AVC_PH_VLU_ISS_S;
      end
    end
  end
  // real-time clock: free running, loadable only in monitor state
  logic rtc_ld;
  assign rtc_ld = iss && par_q.op == `AVC_OP_S2RTC && st_q[`AVC_ST_MONITOR];
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rtc_q <= 64'h0;
    end else if (rtc_ld) begin
      rtc_q <= {s_q[par_q.j][63:2], 2'h0};
    end else begin
      rtc_q <= rtc_q + 64'h1;
    end
  end
  // vector length load with clamp to 64
  logic [31:0] vk;
  assign vk = aval(par_q.k);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vl_q <= `AVC_VL_RST;
    end else if (iss && par_q.op == `AVC_OP_VLLD) begin
      if ($signed(vk) < 0 || vk > `AVC_VL_MAX) vl_q <= `AVC_VL_RST;
      else vl_q <= vk[6:0];
    end
  end
  // status register: error events win over the range code clear
  logic rng;
  assign rng = iss && par_q.op == `AVC_OP_RNG;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= 32'h0000_0000;
    end else begin
      if (wr && paddr == `AVC_OFF_STATUS) st_q[`AVC_ST_MONITOR] <= pwdata[`AVC_ST_MONITOR];
      if (rng) begin
        case (par_q.k)
          3'h0: st_q[`AVC_ST_MEM_HALT] <= 1'b0;
          3'h1: begin
            st_q[`AVC_ST_RD_ERR] <= 1'b0;
            st_q[`AVC_ST_WR_ERR] <= 1'b0;
            st_q[`AVC_ST_MEM_HALT] <= 1'b1;
          end
          3'h2: st_q[`AVC_ST_FLT_TEST] <= 1'b0;
          3'h3: st_q[`AVC_ST_FLT_TEST] <= 1'b1;
          default: st_q[`AVC_ST_FLT_TEST] <= st_q[`AVC_ST_FLT_TEST]; // other k ignored
        endcase
      end
      // recorded whatever the halt and test enables say
      if (range_err.mem_rd) st_q[`AVC_ST_RD_ERR] <= 1'b1;
      if (range_err.mem_wr) st_q[`AVC_ST_WR_ERR] <= 1'b1;
      if (range_err.flt) st_q[`AVC_ST_FLT_ERR] <= 1'b1;
    end
  end
  // halt request only when enabled and a memory range error stands
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) mem_range_halt <= 1'b0;
    else mem_range_halt <= st_q[`AVC_ST_MEM_HALT] &&
                           (st_q[`AVC_ST_RD_ERR] || st_q[`AVC_ST_WR_ERR]);
  end
  // ---- apb read mux ----
  logic [31:0] rmux;
  logic [31:0] busy;
  assign busy = {24'h0, rtc_cnt_q != 8'h00, vsrc_cnt_q != 8'h00, vm_cnt_q != 8'h00,
                 vlu_cnt_q != 8'h00, mul_cnt_q != 8'h00, path_cnt_q != 8'h00,
                 state_q == AVC_STREAM, pend_q};
  always_comb begin
    mapped = 1'b1;
    rmux = 32'h0000_0000;
    case (paddr)
      `AVC_OFF_INSTR: rmux = {15'h0, pend_q, par_q};
      `AVC_OFF_STATUS: rmux = st_q | {31'h0, pend_q};
      `AVC_OFF_VLEN: rmux = {25'h0, vl_q};
      `AVC_OFF_VM_LO: rmux = vm_q[31:0];
      `AVC_OFF_VM_HI: rmux = vm_q[63:32];
      `AVC_OFF_RTC_LO: rmux = rtc_q[31:0];
      `AVC_OFF_RTC_HI: rmux = rtc_q[63:32];
      `AVC_OFF_VIDX: rmux = {26'h0, vidx_q};
      `AVC_OFF_VDAT_LO: rmux = vlo_q;
      `AVC_OFF_VDAT_HI: rmux = 32'h0000_0000;
      `AVC_OFF_BUSY: rmux = busy;
      default: begin
        mapped = 1'b0;
        for (int n = 0; n < 8; n++) begin
          if (paddr == `AVC_OFF_AREG + 8'(4 * n)) begin
            mapped = 1'b1;
            rmux = a_q[n];
          end
          if (paddr == `AVC_OFF_SREG + 8'(8 * n)) begin
            mapped = 1'b1;
            rmux = s_q[n][31:0];
          end
          if (paddr == `AVC_OFF_SREG + 8'(8 * n + 4)) begin
            mapped = 1'b1;
            rmux = s_q[n][63:32];
          end
        end
      end
    endcase
  end
  assign pslverr = acc && pready && !mapped; // unmapped access flagged
  // read data registered at the setup-phase edge, while penable is still low
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) prdata <= 32'h0000_0000;
    else if (psel && !penable && !pwrite) prdata <= mapped ? rmux : 32'h0000_0000;
  end
  // ---- assertions ----
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sub_result_lands_a: assert property (
    iss && par_q.op == `AVC_OP_SUB |=> a_cnt_q[$past(par_q.i)] == `AVC_PH_RES)
    else $error("subtract result phase wrong");
  mul_low_half_a: assert property (
    iss && par_q.op == `AVC_OP_MUL |-> res_d == prod[31:0] && res_ph == `AVC_PH_RES_MUL)
    else $error("multiply result not low half");
  mul_back_hold_a: assert property (
    iss && par_q.op == `AVC_OP_MUL |=> !(iss && par_q.op == `AVC_OP_MUL) [*3])
    else $error("second multiply not held");
  inc_code_six_a: assert property (
    iss && par_q.op == `AVC_OP_INC && par_q.k == 3'h6 |-> res_d == opj - 32'h1)
    else $error("increment code six not minus one");
  kneg_fill_a: assert property (
    iss && par_q.op == `AVC_OP_KNEG |=> ##7 a_q[$past(par_q.i, 8)][31:6] == 26'h3ff_ffff)
    else $error("negative constant not ones filled");
  mask_zero_len_a: assert property (
    mask_iss && vl_q == 7'h00 |=> vm_q == 64'h0 && vm_cnt_q == `AVC_PH_VM_ZERO)
    else $error("zero length mask not clear");
  rtc_low_bits_a: assert property (
    rtc_ld |=> rtc_q[1:0] == 2'h0)
    else $error("clock low bits not forced");
  rtc_locked_a: assert property (
    iss && par_q.op == `AVC_OP_S2RTC && !st_q[`AVC_ST_MONITOR] |=> rtc_q == $past(rtc_q) + 64'h1)
    else $error("clock loaded outside monitor state");
  vl_clamp_a: assert property (
    iss && par_q.op == `AVC_OP_VLLD |=> vl_q <= `AVC_VL_RST && !iss [*8])
    else $error("length not clamped or issue too soon");
  err_record_a: assert property (
    range_err.mem_rd |=> st_q[`AVC_ST_RD_ERR])
    else $error("memory read range error lost");
  issue_gate_a: assert property (
    iss |-> next_cnt_q == 8'h00 && pend_q)
    else $error("issue while spacing active");
endmodule : avc_core
`default_nettype wire

// ---- src/avc_pkg.sv ----
// types shared by the address and vector control block
package avc_pkg;
  // one instruction parcel: opcode and i, j, k designators
  typedef struct packed {
    logic [6:0] op;
    logic [2:0] i;
    logic [2:0] j;
    logic [2:0] k;
  } avc_parcel_type;
  // mask streaming sequencer
  typedef enum logic [1:0] {
    AVC_IDLE = 2'b01,
    AVC_STREAM = 2'b10
  } avc_state_type;
  // range error event inputs
  typedef struct packed {
    logic mem_rd;
    logic mem_wr;
    logic flt;
  } avc_err_type;
endpackage : avc_pkg

// ---- verif/avc_err_src.sv ----
// range error pulse source standing in for the memory and float units
`default_nettype none
module avc_err_src
  import avc_pkg::*;
(
  input wire logic pclk,
  input wire logic [2:0] fire,
  output var avc_err_type range_err
);
  timeunit 1ns;
  timeprecision 1ns;
  // quiet before the first edge so the core never sees an unknown event
  initial range_err = '0;
  // a request becomes a one-cycle registered strobe, as a unit raises it
  always @(posedge pclk) range_err <= fire;
endmodule : avc_err_src
`default_nettype wire

// ---- verif/test_address_and_vector_control_ops.sv ----
// self-checking bench: apb register and instruction sequences
`include "avc_consts.svh"
`default_nettype none
module test_address_and_vector_control_ops
  import avc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, serr;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic pready, pslverr, mem_range_halt;
  logic [2:0] fire = 3'h0; // error strobes for the partner
  avc_err_type range_err;
  int err_count = 0, n_checks = 0;
  // offsets per k code; mask words per test code; element values
  logic [31:0] inc_t [8] = '{32'h0, 32'h1, '1, 32'h0, 32'h0, 32'h1, '1, 32'h0};
  logic [31:0] vm_t [4] = '{32'h8000_0000, 32'h6000_0000, 32'hc000_0000, 32'h2000_0000};
  logic [31:0] vel_t [3] = '{32'h0, 32'h5, '1};
  // range codes in order and the status word each leaves behind
  logic [2:0] rk_t [4] = '{3'h1, 3'h3, 3'h2, 3'h0};
  logic [31:0] st_t [4] = '{32'h0020_8000, 32'h0024_8000, 32'h0020_8000, 32'h0020_0000};
  avc_core u_avc_core (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .range_err(range_err), .mem_range_halt(mem_range_halt));
  avc_err_src u_avc_err_src (.pclk(pclk), .fire(fire), .range_err(range_err));
  always #50 pclk = ~pclk;
  task automatic results();
    if (err_count == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : results
  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      err_count++;
      $display("[ERR] %0t got %h expected %h", $time, g, e);
    end
  endtask : cmp
  // a hung wait counts as a mismatch and ends the run
  task automatic tmo(input int n);
    if (n > 99) begin
      err_count++;
      results();
    end
  endtask : tmo
  // one transfer; request held until the edge that sees pready high, then one idle edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      tmo(++n);
      @(posedge pclk);
    end
    q = prdata;
    serr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    cmp(q, e);
  endtask : rd
  // issue one parcel, then poll the busy flags until the pipe drains
  task automatic op(input logic [6:0] o, input logic [2:0] i, input logic [2:0] j,
                    input logic [2:0] k);
    int n;
    n = 0;
    apb(1'b1, `AVC_OFF_INSTR, {16'h0, o, i, j, k});
    q = 32'h1;
    while (q !== 32'h0) begin
      tmo(++n);
      apb(1'b0, `AVC_OFF_BUSY, 32'h0);
    end
  endtask : op
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b1, 8'h48, 32'h1_0001);
    apb(1'b1, 8'h4c, 32'h1_0003);
    op(`AVC_OP_SUB, 3'h1, 3'h2, 3'h3);
    rd(8'h44, 32'hffff_fffe);
    // two multiplies back to back: the second must wait, not be lost
    apb(1'b1, `AVC_OFF_INSTR, {16'h0, `AVC_OP_MUL, 3'h4, 3'h2, 3'h3});
    op(`AVC_OP_MUL, 3'h5, 3'h2, 3'h2);
    rd(8'h50, 32'h0004_0003);
    rd(8'h54, 32'h0002_0001);
    for (int k = 0; k < 8; k++) begin
      op(`AVC_OP_INC, 3'h6, 3'h2, 3'(k));
      rd(8'h58, 32'h1_0001 + inc_t[k]);
    end
    apb(1'b1, 8'h88, 32'h1234_5678);
    apb(1'b1, 8'h8c, 32'hdead_beef);
    op(`AVC_OP_S2A, 3'h7, 3'h1, 3'h0);
    rd(8'h5c, 32'h1234_5678);
    op(`AVC_OP_VLRD, 3'h1, 3'h0, 3'h0);
    rd(8'h44, 32'h40);
    op(`AVC_OP_KPOS, 3'h1, 3'h5, 3'h2);
    rd(8'h44, 32'h2a);
    op(`AVC_OP_KNEG, 3'h1, 3'h5, 3'h2);
    rd(8'h44, 32'hffff_ffea);
    op(`AVC_OP_VLLD, 3'h0, 3'h0, 3'h1);
    rd(`AVC_OFF_VLEN, 32'h40);
    apb(1'b1, 8'h44, 32'h3);
    op(`AVC_OP_VLLD, 3'h0, 3'h0, 3'h1);
    rd(`AVC_OFF_VLEN, 32'h3);
    apb(1'b1, `AVC_OFF_VIDX, 32'h0);
    for (int e = 0; e < 3; e++) begin
      apb(1'b1, `AVC_OFF_VDAT_LO, vel_t[e]);
      apb(1'b1, `AVC_OFF_VDAT_HI, {32{vel_t[e][31]}});
    end
    for (int c = 0; c < 4; c++) begin
      op(7'(`AVC_OP_VMZ + c), 3'h0, 3'h0, 3'h0);
      rd(`AVC_OFF_VM_HI, vm_t[c]);
    end
    op(`AVC_OP_S2VM, 3'h0, 3'h1, 3'h0);
    rd(`AVC_OFF_VM_LO, 32'h1234_5678);
    apb(1'b1, 8'h44, 32'h0);
    op(`AVC_OP_VLLD, 3'h0, 3'h0, 3'h1);
    op(`AVC_OP_VMZ, 3'h0, 3'h0, 3'h0);
    rd(`AVC_OFF_VM_LO, 32'h0);
    // clock load is refused until software sets the monitor bit
    op(`AVC_OP_S2RTC, 3'h0, 3'h1, 3'h0);
    rd(`AVC_OFF_RTC_HI, 32'h0);
    apb(1'b1, `AVC_OFF_STATUS, 32'h0020_0000);
    op(`AVC_OP_S2RTC, 3'h0, 3'h1, 3'h0);
    rd(`AVC_OFF_RTC_HI, 32'hdead_beef);
    op(`AVC_OP_RNG, 3'h0, 3'h0, 3'h1);
    fire <= 3'h4;
    @(posedge pclk);
    fire <= 3'h0;
    @(posedge pclk); // strobe is registered once more before status sees it
    rd(`AVC_OFF_STATUS, 32'h0020_a000);
    cmp({31'h0, mem_range_halt}, 32'h1);
    for (int r = 0; r < 4; r++) begin
      op(`AVC_OP_RNG, 3'h0, 3'h0, rk_t[r]);
      rd(`AVC_OFF_STATUS, st_t[r]);
    end
    fire <= 3'h3;
    @(posedge pclk);
    fire <= 3'h0;
    @(posedge pclk);
    rd(`AVC_OFF_STATUS, 32'h0021_4000);
    rd(8'h3c, 32'h0);
    cmp({31'h0, serr}, 32'h1);
    results();
  end
endmodule : test_address_and_vector_control_ops
`default_nettype wire
